/* dv/lcch_host_model.sv */
// Host-side command source for the limit comparator command handler
`timescale 1ns/1ps
module lcch_host_model (
  input  wire logic           clk_in,
  output logic                cmd_valid_out,
  output lcch_pkg::lcch_cmd_t cmd_out
);
  import lcch_pkg::*;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out       = '0;
  end
  // Valid stays up between calls so commands can run back to back
  task automatic issue(input lcch_op_t op, input logic q, input lcch_sfx_t s,
                       input logic [31:0] v);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_out       = '{op: op, query: q, sfx: s, value: v};
  endtask : issue
  // An idle port must not keep showing the last command
  task automatic idle();
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_out       = ~cmd_out;
  endtask : idle
endmodule : lcch_host_model

/* dv/lcch_top_tb.sv */
// Self-checking bench for the limit comparator command handler
`timescale 1ns/1ps
`include "lcch_consts.svh"
module lcch_top_tb;
  import lcch_pkg::*;
  localparam logic [63:0] OHM = `LCCH_SCALE_OHM;
  logic clk_in = 1'b0, reset_in = 1'b1, cmd_valid_in, rsp_valid_out;
  logic meas_start_in, meas_done_in, meas_running_in, cal_mode_in;
  logic relay_enable_out, clear_static_out, result_valid_out;
  logic result_low_out, result_high_out, relay_drive_out;
  logic [63:0] meas_value_in, low_active_out, high_active_out, lo;
  logic [9:0]  eval_delay_out;
  logic [31:0] v;
  logic [65:0] e;
  logic [65:0] exp_q [$];
  lcch_cmd_t   cmd_in;
  lcch_rsp_t   rsp_out;
  lcch_disp_t  display_unit_out;
  lcch_sfx_t   sl [5] = '{LCCH_SFX_UOHM, LCCH_SFX_MOHM, LCCH_SFX_OHM, LCCH_SFX_KOHM, LCCH_SFX_NONE};
  logic [63:0] sc [5] = '{`LCCH_SCALE_UOHM, `LCCH_SCALE_MOHM, OHM, `LCCH_SCALE_KOHM, OHM};
  int mismatches = 0, total_checks = 0;

  always #5 clk_in = ~clk_in;

  lcch_host_model host_u (.clk_in(clk_in), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));
  lcch_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
    .meas_start_in(meas_start_in), .meas_done_in(meas_done_in),
    .meas_value_in(meas_value_in), .meas_running_in(meas_running_in),
    .cal_mode_in(cal_mode_in), .relay_enable_out(relay_enable_out),
    .clear_static_out(clear_static_out), .low_active_out(low_active_out),
    .high_active_out(high_active_out), .eval_delay_out(eval_delay_out),
    .display_unit_out(display_unit_out), .result_valid_out(result_valid_out),
    .result_low_out(result_low_out), .result_high_out(result_high_out),
    .relay_drive_out(relay_drive_out));

  task automatic check(input logic [65:0] seen, input logic [65:0] expv);
    total_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  // NAK data is not defined, so only the ack bit is noted then
  task automatic cmd(input lcch_op_t op, input logic q, input lcch_sfx_t s,
                     input logic [31:0] val, input logic ack, input logic [63:0] d);
    exp_q.push_back({q & ack, ack, (q & ack) ? d : 64'h0});
    host_u.issue(op, q, s, val);
  endtask : cmd

  task automatic settle();
    host_u.idle();
    repeat (2) @(negedge clk_in);
  endtask : settle

  task automatic meas(input logic st, input logic dn, input logic [63:0] val);
    @(negedge clk_in);
    meas_start_in = st;
    meas_done_in  = dn;
    meas_value_in = val;
    @(negedge clk_in);
    meas_start_in = 1'b0;
    meas_done_in  = 1'b0;
    meas_value_in = ~val;
    @(negedge clk_in);
  endtask : meas

  task automatic print_verdict();
    $display("Counts: checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  always @(negedge clk_in) begin
    if (rsp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(66'h0, 66'h1);
      end else begin
        e = exp_q.pop_front();
        check({e[65], rsp_out.ack, e[65] ? rsp_out.data : 64'h0}, e);
      end
    end
  end

  initial begin
    #200_000;
    mismatches++;
    print_verdict();
  end

  initial begin
    {meas_start_in, meas_done_in, meas_running_in, cal_mode_in} = 4'h0;
    meas_value_in = 64'h0;
    lo = 64'h0;
    void'($urandom(32'h39c4));
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    check(66'(relay_enable_out), 66'h1);
    check(66'(clear_static_out), 66'h1);
    check(66'(eval_delay_out), 66'h1);
    $display("Test reset done");
    for (int i = 0; i < 2; i++) begin
      cmd(LCCH_OP_RELAY, 0, LCCH_SFX_NONE, 32'(i), 1, 0);
      cmd(LCCH_OP_RELAY, 1, LCCH_SFX_NONE, 0, 1, 64'(i));
      cmd(LCCH_OP_CLEAR_MODE, 0, LCCH_SFX_NONE, 32'(i), 1, 0);
      cmd(LCCH_OP_CLEAR_MODE, 1, LCCH_SFX_NONE, 0, 1, 64'(i));
      settle();
      check(66'(relay_enable_out), 66'(i));
      check(66'(clear_static_out), 66'(i));
    end
    cmd(LCCH_OP_RELAY, 0, LCCH_SFX_NONE, 2, 0, 0);
    cmd(LCCH_OP_ADOPT, 0, LCCH_SFX_NONE, 0, 0, 0);
    cmd(LCCH_OP_LOW, 0, lcch_sfx_t'(3'h5), 1, 0, 0);
    cmd(lcch_op_t'(3'h7), 1, LCCH_SFX_NONE, 0, 0, 0);
    $display("Test relay and clear mode done");
    for (int i = 0; i < 5; i++) begin
      v = $urandom_range(1000, 1);
      cmd(LCCH_OP_LOW, 0, sl[i], v, 1, 0);
      cmd(LCCH_OP_ADOPT, 1, LCCH_SFX_NONE, 0, 1, 0);
      cmd(LCCH_OP_HIGH, 0, sl[i], v + 1, 1, 0);
      settle();
      check(66'(low_active_out), 66'(lo));
      cmd(LCCH_OP_ADOPT, 1, LCCH_SFX_NONE, 0, 1, 1);
      cmd(LCCH_OP_LOW, 1, LCCH_SFX_NONE, 0, 1, 64'(v) * sc[i]);
      cmd(LCCH_OP_HIGH, 1, LCCH_SFX_NONE, 0, 1, 64'(v + 1) * sc[i]);
      settle();
      lo = 64'(v) * sc[i];
      check(66'(low_active_out), 66'(lo));
      check(66'(high_active_out), 66'(64'(v + 1) * sc[i]));
    end
    $display("Test limits done");
    cmd(LCCH_OP_LOW, 0, LCCH_SFX_OHM, 9, 1, 0);
    cmd(LCCH_OP_HIGH, 0, LCCH_SFX_OHM, 4, 1, 0);
    cmd(LCCH_OP_ADOPT, 1, LCCH_SFX_NONE, 0, 1, 0);
    cmd(LCCH_OP_LOW, 0, LCCH_SFX_OHM, 2, 1, 0);
    cmd(LCCH_OP_HIGH, 0, LCCH_SFX_OHM, 5, 1, 0);
    settle();
    cal_mode_in = 1'b1;
    cmd(LCCH_OP_ADOPT, 1, LCCH_SFX_NONE, 0, 0, 0);
    settle();
    cal_mode_in = 1'b0;
    meas_running_in = 1'b1;
    cmd(LCCH_OP_ADOPT, 1, LCCH_SFX_NONE, 0, 0, 0);
    settle();
    meas_running_in = 1'b0;
    check(66'(low_active_out), 66'(lo));
    cmd(LCCH_OP_ADOPT, 1, LCCH_SFX_NONE, 0, 1, 1);
    settle();
    check(66'(high_active_out), 66'(OHM * 5));
    $display("Test adopt refusals done");
    cmd(LCCH_OP_DELAY, 0, LCCH_SFX_NONE, 0, 0, 0);
    cmd(LCCH_OP_DELAY, 0, LCCH_SFX_NONE, 1000, 0, 0);
    cmd(LCCH_OP_DELAY, 0, LCCH_SFX_NONE, 999, 1, 0);
    cmd(LCCH_OP_DELAY, 1, LCCH_SFX_NONE, 0, 1, 999);
    cmd(LCCH_OP_DELAY, 0, LCCH_SFX_NONE, 2, 1, 0);
    settle();
    meas(1, 0, 0);
    repeat (2) meas(0, 1, 64'($urandom_range(1999999, 0)));
    check(66'(result_valid_out), 66'h0);
    meas(0, 1, 64'($urandom_range(1999999, 0)));
    check(66'({result_valid_out, result_low_out, result_high_out}), 66'h6);
    check(66'(relay_drive_out), 66'h1);
    meas(1, 0, 0);
    check(66'(result_valid_out), 66'h0);
    cmd(LCCH_OP_CLEAR_MODE, 0, LCCH_SFX_NONE, 0, 1, 0);
    settle();
    repeat (3) meas(0, 1, OHM * 5 + 64'($urandom_range(9999, 1)));
    meas(1, 0, 0);
    check(66'({result_valid_out, result_low_out, result_high_out}), 66'h5);
    cmd(LCCH_OP_RELAY, 0, LCCH_SFX_NONE, 0, 1, 0);
    settle();
    check(66'(relay_drive_out), 66'h0);
    $display("Test evaluation done");
    for (int i = 0; i < 5; i++) begin
      cmd(LCCH_OP_UNIT, 0, LCCH_SFX_NONE, 32'(i), 1, 0);
      cmd(LCCH_OP_UNIT, 1, LCCH_SFX_NONE, 0, 1, 64'(i));
    end
    cmd(LCCH_OP_UNIT, 0, LCCH_SFX_NONE, 5, 0, 0);
    settle();
    check(66'(display_unit_out), 66'(LCCH_DISP_OHM_KFT));
    $display("Test display unit done");
    repeat (3) @(negedge clk_in);
    check(66'(exp_q.size()), 66'h0);
    print_verdict();
  end
endmodule : lcch_top_tb

/* rtl/lcch_consts.svh */
// Constants for the limit comparator command handler
`ifndef LCCH_CONSTS_SVH
`define LCCH_CONSTS_SVH
`define LCCH_VAL_W          32
`define LCCH_LIM_W          64
`define LCCH_DELAY_W        10
`define LCCH_SCALE_UOHM     64'h0000_0000_0000_0001
`define LCCH_SCALE_MOHM     64'h0000_0000_0000_03E8
`define LCCH_SCALE_OHM      64'h0000_0000_000F_4240
`define LCCH_SCALE_KOHM     64'h0000_0000_3B9A_CA00
`define LCCH_DELAY_MIN      10'h001
`define LCCH_DELAY_MAX      10'h3E7
`define LCCH_DELAY_RST      10'h001
`define LCCH_RELAY_RST      1'h1
`define LCCH_CLEAR_RST      1'h1
`define LCCH_ANS_TRUE       64'h0000_0000_0000_0001
`define LCCH_ANS_FALSE      64'h0000_0000_0000_0000
`endif

/* rtl/lcch_eval_counter.sv */
// Counts measurements after a start and flags those that get evaluated
`timescale 1ns/1ps
module lcch_eval_counter #(
  parameter int W = 10
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic         start_in,
  input  wire logic         done_in,
  input  wire logic [W-1:0] count_in,
  output logic              eval_out
);
  logic [W-1:0] seen_reg;
  logic [W-1:0] seen_next;
  wire          skipping = (seen_reg < count_in);
  // Saturates at the programmed count, so later measurements are all evaluated
  assign seen_next = start_in ? '0 : (done_in && skipping) ? seen_reg + 1'b1 : seen_reg;
  assign eval_out  = done_in && !start_in && !skipping;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      seen_reg <= '0;
    end else begin
      seen_reg <= seen_next;
    end
  end
endmodule : lcch_eval_counter

/* rtl/lcch_pkg.sv */
// Types for the limit comparator command handler
package lcch_pkg;
  typedef enum logic [2:0] {
    LCCH_OP_RELAY, LCCH_OP_CLEAR_MODE, LCCH_OP_LOW, LCCH_OP_HIGH,
    LCCH_OP_ADOPT, LCCH_OP_DELAY, LCCH_OP_UNIT
  } lcch_op_t;
  typedef enum logic [2:0] {
    LCCH_SFX_NONE, LCCH_SFX_UOHM, LCCH_SFX_MOHM, LCCH_SFX_OHM, LCCH_SFX_KOHM
  } lcch_sfx_t;
  typedef enum logic [2:0] {
    LCCH_DISP_OHM, LCCH_DISP_OHM_M, LCCH_DISP_OHM_KM, LCCH_DISP_OHM_FT, LCCH_DISP_OHM_KFT
  } lcch_disp_t;
  typedef struct packed {
    lcch_op_t    op;
    logic        query;
    lcch_sfx_t   sfx;
    logic [31:0] value;
  } lcch_cmd_t;
  typedef struct packed {
    logic        ack;
    logic [63:0] data;
  } lcch_rsp_t;
endpackage : lcch_pkg

/* rtl/lcch_top.sv */
// Limit comparator command handler: decoded command port, limits, comparator
`timescale 1ns/1ps
`include "lcch_consts.svh"
module lcch_top #(
  parameter int DELAY_W = `LCCH_DELAY_W
) (
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic                cmd_valid_in,
  input  wire lcch_pkg::lcch_cmd_t cmd_in,
  output logic                     rsp_valid_out,
  output lcch_pkg::lcch_rsp_t      rsp_out,
  input  wire logic                meas_start_in,
  input  wire logic                meas_done_in,
  input  wire logic [63:0]         meas_value_in,
  input  wire logic                meas_running_in,
  input  wire logic                cal_mode_in,
  output logic                     relay_enable_out,
  output logic                     clear_static_out,
  output logic [63:0]              low_active_out,
  output logic [63:0]              high_active_out,
  output logic [DELAY_W-1:0]       eval_delay_out,
  output lcch_pkg::lcch_disp_t     display_unit_out,
  output logic                     result_valid_out,
  output logic                     result_low_out,
  output logic                     result_high_out,
  output logic                     relay_drive_out
);
  import lcch_pkg::*;

  logic               relay_en_reg;
  logic               clear_static_reg;
  logic [63:0]        low_stage_reg;
  logic [63:0]        high_stage_reg;
  logic               low_pend_reg;
  logic               high_pend_reg;
  logic [63:0]        low_act_reg;
  logic [63:0]        high_act_reg;
  logic [DELAY_W-1:0] delay_reg;
  lcch_disp_t         disp_reg;
  logic               rsp_valid_reg;
  lcch_rsp_t          rsp_reg;
  lcch_rsp_t          rsp_next;
  logic               res_valid_reg;
  logic               res_low_reg;
  logic               res_high_reg;
  logic [63:0]        scaled;
  logic               sfx_ok;
  logic               eval_now;

  lcch_unit_scaler u_scaler (
    .value_in   (cmd_in.value),
    .sfx_in     (cmd_in.sfx),
    .scaled_out (scaled),
    .sfx_ok_out (sfx_ok)
  );

  lcch_eval_counter #(.W(DELAY_W)) u_eval (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .start_in (meas_start_in),
    .done_in  (meas_done_in),
    .count_in (delay_reg),
    .eval_out (eval_now)
  );

  // Command decode
  wire is_set    = cmd_valid_in && !cmd_in.query;
  wire is_query  = cmd_valid_in && cmd_in.query;
  wire bool_ok   = (cmd_in.value <= 32'h0000_0001);
  wire delay_ok  = (cmd_in.value >= 32'(`LCCH_DELAY_MIN))
                && (cmd_in.value <= 32'(`LCCH_DELAY_MAX));
  wire disp_ok   = (cmd_in.value <= 32'(LCCH_DISP_OHM_KFT));
  wire set_relay = is_set && cmd_in.op == LCCH_OP_RELAY && bool_ok;
  wire set_clear = is_set && cmd_in.op == LCCH_OP_CLEAR_MODE && bool_ok;
  wire set_low   = is_set && cmd_in.op == LCCH_OP_LOW && sfx_ok;
  wire set_high  = is_set && cmd_in.op == LCCH_OP_HIGH && sfx_ok;
  wire set_delay = is_set && cmd_in.op == LCCH_OP_DELAY && delay_ok;
  wire set_disp  = is_set && cmd_in.op == LCCH_OP_UNIT && disp_ok;
  wire ask_adopt = is_query && cmd_in.op == LCCH_OP_ADOPT;
  // Adopt needs a free instrument; refusal gives a negative acknowledge
  wire adopt_blocked = cal_mode_in || meas_running_in;
  // A reversed pair is not adopted either, keeping the window meaningful
  wire adopt_ready   = low_pend_reg && high_pend_reg
                    && (low_stage_reg <= high_stage_reg);
  wire adopt_go      = ask_adopt && !adopt_blocked && adopt_ready;
  wire set_ok        = set_relay || set_clear || set_low || set_high
                    || set_delay || set_disp;
  wire query_ok      = is_query && (cmd_in.op != LCCH_OP_ADOPT || !adopt_blocked);

  always_comb begin
    rsp_next      = '0;
    rsp_next.ack  = set_ok || query_ok;
    if (is_query) begin
      case (cmd_in.op)
        LCCH_OP_RELAY:      rsp_next.data = {63'h0, relay_en_reg};
        LCCH_OP_CLEAR_MODE: rsp_next.data = {63'h0, clear_static_reg};
        LCCH_OP_LOW:        rsp_next.data = low_act_reg;
        LCCH_OP_HIGH:       rsp_next.data = high_act_reg;
        LCCH_OP_ADOPT:      rsp_next.data = adopt_go ? `LCCH_ANS_TRUE
                                                     : `LCCH_ANS_FALSE;
        LCCH_OP_DELAY:      rsp_next.data = 64'(delay_reg);
        LCCH_OP_UNIT:       rsp_next.data = 64'(disp_reg);
        default:            rsp_next.ack  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
    end else begin
      rsp_valid_reg <= cmd_valid_in;
      rsp_reg       <= rsp_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      relay_en_reg     <= `LCCH_RELAY_RST;
      clear_static_reg <= `LCCH_CLEAR_RST;
      delay_reg        <= DELAY_W'(`LCCH_DELAY_RST);
      disp_reg         <= LCCH_DISP_OHM;
    end else begin
      if (set_relay) relay_en_reg <= cmd_in.value[0];
      if (set_clear) clear_static_reg <= cmd_in.value[0];
      if (set_delay) delay_reg <= cmd_in.value[DELAY_W-1:0];
      if (set_disp) disp_reg <= lcch_disp_t'(cmd_in.value[2:0]);
    end
  end

  // Staged limits; active copies move only on a successful adopt
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_stage_reg  <= '0;
      high_stage_reg <= '0;
      low_pend_reg   <= 1'b0;
      high_pend_reg  <= 1'b0;
      low_act_reg    <= '0;
      high_act_reg   <= '0;
    end else begin
      if (set_low) begin
        low_stage_reg <= scaled;
      end
      if (set_high) begin
        high_stage_reg <= scaled;
      end
      low_pend_reg  <= set_low || (low_pend_reg && !adopt_go);
      high_pend_reg <= set_high || (high_pend_reg && !adopt_go);
      if (adopt_go) begin
        low_act_reg  <= low_stage_reg;
        high_act_reg <= high_stage_reg;
      end
    end
  end

  // Comparator result; an evaluation in the start cycle cannot occur
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      res_valid_reg <= 1'b0;
      res_low_reg   <= 1'b0;
      res_high_reg  <= 1'b0;
    end else if (eval_now) begin
      res_valid_reg <= 1'b1;
      res_low_reg   <= meas_value_in < low_act_reg;
      res_high_reg  <= meas_value_in > high_act_reg;
    end else if (meas_start_in && clear_static_reg) begin
      res_valid_reg <= 1'b0;
      res_low_reg   <= 1'b0;
      res_high_reg  <= 1'b0;
    end
  end

  assign rsp_valid_out    = rsp_valid_reg;
  assign rsp_out          = rsp_reg;
  assign relay_enable_out = relay_en_reg;
  assign clear_static_out = clear_static_reg;
  assign low_active_out   = low_act_reg;
  assign high_active_out  = high_act_reg;
  assign eval_delay_out   = delay_reg;
  assign display_unit_out = disp_reg;
  assign result_valid_out = res_valid_reg;
  assign result_low_out   = res_low_reg;
  assign result_high_out  = res_high_reg;
  // Relay follows a failed result only while its function is enabled
  assign relay_drive_out  = relay_en_reg && res_valid_reg
                         && (res_low_reg || res_high_reg);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_relay_set;
    set_relay |=> relay_enable_out == $past(cmd_in.value[0]);
  endproperty
  a_relay_set: assert property (p_relay_set) else $error("relay enable not set");

  property p_relay_query;
    is_query && cmd_in.op == LCCH_OP_RELAY
      |=> rsp_out.data == {63'h0, $past(relay_en_reg)} && rsp_out.ack;
  endproperty
  a_relay_query: assert property (p_relay_query) else $error("relay query wrong");

  property p_static_clear;
    meas_start_in && clear_static_reg && !eval_now |=> !result_valid_out;
  endproperty
  a_static_clear: assert property (p_static_clear) else $error("static clear missed");

  property p_dynamic_keep;
    meas_start_in && !clear_static_reg && !eval_now && result_valid_out
      |=> result_valid_out && $stable(result_low_out) && $stable(result_high_out);
  endproperty
  a_dynamic_keep: assert property (p_dynamic_keep) else $error("dynamic result lost");

  sequence s_limit_sent;
    set_low || set_high;
  endsequence
  property p_pending_hold;
    s_limit_sent and !adopt_go |=> $stable(low_active_out) && $stable(high_active_out);
  endproperty
  a_pending_hold: assert property (p_pending_hold) else $error("limit used early");

  property p_adopt_copy;
    adopt_go |=> low_active_out == $past(low_stage_reg)
             && high_active_out == $past(high_stage_reg) && rsp_out.data == `LCCH_ANS_TRUE;
  endproperty
  a_adopt_copy: assert property (p_adopt_copy) else $error("adopt did not copy");

  property p_adopt_fail;
    ask_adopt && !adopt_go |=> rsp_out.data == `LCCH_ANS_FALSE
      && $stable(low_active_out) && $stable(high_active_out);
  endproperty
  a_adopt_fail: assert property (p_adopt_fail) else $error("failed adopt changed limits");

  property p_adopt_refused;
    ask_adopt && (cal_mode_in || meas_running_in) |=> rsp_valid_out && !rsp_out.ack;
  endproperty
  a_adopt_refused: assert property (p_adopt_refused) else $error("adopt not refused");

  property p_one_limit;
    ask_adopt && !(low_pend_reg && high_pend_reg) |=> !$changed(low_active_out);
  endproperty
  a_one_limit: assert property (p_one_limit) else $error("single limit adopted");

  property p_bad_delay_nak;
    is_set && cmd_in.op == LCCH_OP_DELAY && !delay_ok
      |=> !rsp_out.ack && $stable(eval_delay_out);
  endproperty
  a_bad_delay_nak: assert property (p_bad_delay_nak) else $error("bad delay taken");

  property p_delay_range;
    eval_delay_out >= DELAY_W'(`LCCH_DELAY_MIN) && eval_delay_out <= DELAY_W'(`LCCH_DELAY_MAX);
  endproperty
  a_delay_range: assert property (p_delay_range) else $error("delay out of range");
endmodule : lcch_top

/* rtl/lcch_unit_scaler.sv */
// Scales a limit mantissa by its unit suffix into micro-ohm counts
`timescale 1ns/1ps
`include "lcch_consts.svh"
module lcch_unit_scaler (
  input  wire logic [31:0]        value_in,
  input  wire lcch_pkg::lcch_sfx_t sfx_in,
  output logic      [63:0]        scaled_out,
  output logic                    sfx_ok_out
);
  import lcch_pkg::*;
  logic [63:0] scale;
  // Missing suffix means ohms
  assign scale = (sfx_in == LCCH_SFX_UOHM) ? `LCCH_SCALE_UOHM :
                 (sfx_in == LCCH_SFX_MOHM) ? `LCCH_SCALE_MOHM :
                 (sfx_in == LCCH_SFX_KOHM) ? `LCCH_SCALE_KOHM :
                                             `LCCH_SCALE_OHM;
  assign sfx_ok_out = (sfx_in <= LCCH_SFX_KOHM);
  // 32-bit mantissa times 1e9 fits in 64 bits, so no overflow check needed
  assign scaled_out = {32'h0000_0000, value_in} * scale;
endmodule : lcch_unit_scaler
